// ===== core/nvsc_pkg.sv
package nvsc_pkg;
    // ****************************************
    // pin widths and key length
    // ****************************************
    localparam int NVSC_AW = 15;
    localparam int NVSC_DW = 8;
    localparam int NVSC_KEY_AW = 14;
    localparam int NVSC_KEY_LEN = 6;
    // ****************************************
    // key addresses
    // ****************************************
    localparam logic [13:0] NVSC_KEY0 = 14'h0E38;
    localparam logic [13:0] NVSC_KEY1 = 14'h31C7;
    localparam logic [13:0] NVSC_KEY2 = 14'h03E0;
    localparam logic [13:0] NVSC_KEY3 = 14'h3C1F;
    localparam logic [13:0] NVSC_KEY4 = 14'h303F;
    localparam logic [13:0] NVSC_KEY_STORE = 14'h0FC0;
    localparam logic [13:0] NVSC_KEY_RECALL = 14'h0C63;
    // ****************************************
    // timing
    // ****************************************
    localparam int NVSC_CLK_NS = 10;
    localparam int NVSC_ACC_NS = 45;
    localparam int NVSC_ACC_CYC =
        (NVSC_ACC_NS + NVSC_CLK_NS - 1) / NVSC_CLK_NS;
    localparam int NVSC_STORE_US = 10;
    localparam int NVSC_STORE_CYC = NVSC_STORE_US * 1000 / NVSC_CLK_NS;
    localparam int NVSC_RECALL_US = 20;
    localparam int NVSC_RECALL_CYC = NVSC_RECALL_US * 1000 / NVSC_CLK_NS;
    localparam int NVSC_HRECALL_US = 40;
    localparam int NVSC_HRECALL_CYC = NVSC_HRECALL_US * 1000 / NVSC_CLK_NS;
    localparam int NVSC_CW = 24;
    // ****************************************
    // commands and sequencer states
    // ****************************************
    localparam logic [1:0] NVSC_CMD_READ = 2'h0;
    localparam logic [1:0] NVSC_CMD_WRITE = 2'h1;
    localparam logic [1:0] NVSC_CMD_STORE = 2'h2;
    localparam logic [1:0] NVSC_CMD_RECALL = 2'h3;
    typedef enum logic [4:0] {
        NVSC_IDLE = 5'h01,
        NVSC_STRB = 5'h02,
        NVSC_GAP = 5'h04,
        NVSC_WAIT = 5'h08,
        NVSC_DONE = 5'h10
    } nvsc_state_e;
endpackage

// ===== core/nvsc_tmr_if.sv
`timescale 1ns/1ps
interface nvsc_tmr_if;
    logic load;
    logic [23:0] count;
    logic expired;
    modport ctrl (output load, output count, input expired);
    modport tmr (input load, input count, output expired);
endinterface

// ===== core/nvsc_timer.sv
`timescale 1ns/1ps
module nvsc_timer
    import nvsc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // control
    nvsc_tmr_if.tmr t
);
    logic [NVSC_CW-1:0] cnt_reg;
    logic [NVSC_CW-1:0] cnt_next;
    logic exp_reg;
    logic exp_next;
    always_comb begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (t.load) begin
            cnt_next = t.count;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
            exp_next = (cnt_reg == {{(NVSC_CW-1){1'b0}}, 1'b1});
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end
    assign t.expired = exp_reg;
endmodule

// ===== core/nvsc_ctrl.sv
`timescale 1ns/1ps
module nvsc_ctrl
    import nvsc_pkg::*;
#(
    parameter int STORE_CYC = NVSC_STORE_CYC,
    parameter int RECALL_CYC = NVSC_RECALL_CYC,
    parameter int HRECALL_CYC = NVSC_HRECALL_CYC
)(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // user command
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [NVSC_AW-1:0] cmd_addr_i,
    input wire logic [NVSC_DW-1:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [NVSC_DW-1:0] rsp_rdata_o,
    // device pins
    output logic [NVSC_AW-1:0] byte_address_o,
    input wire logic [NVSC_DW-1:0] byte_lanes_i,
    output logic [NVSC_DW-1:0] byte_lanes_o,
    output logic byte_lanes_oe_n_o,
    output logic ce_n_o,
    output logic we_n_o,
    output logic oe_n_o
);
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // ****************************************
    // checks and synchroniser
    // ****************************************
    if (STORE_CYC < 1 || RECALL_CYC < 1 || HRECALL_CYC < 1 ||
        STORE_CYC >= (1 << NVSC_CW) || RECALL_CYC >= (1 << NVSC_CW) ||
        HRECALL_CYC >= (1 << NVSC_CW)) begin : g_bad_timing
        $error("nvsc_ctrl: bad timing parameter");
    end
    logic [NVSC_DW-1:0] din_s1_reg;
    logic [NVSC_DW-1:0] din_s2_reg;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            din_s1_reg <= '0;
            din_s2_reg <= '0;
        end else begin
            din_s1_reg <= byte_lanes_i;
            din_s2_reg <= din_s1_reg;
        end
    end
    // ****************************************
    // key address table
    // ****************************************
    function automatic logic [NVSC_KEY_AW-1:0] key_addr(
        input logic [2:0] idx, input logic rec);
        case (idx)
            3'h0: key_addr = NVSC_KEY0;
            3'h1: key_addr = NVSC_KEY1;
            3'h2: key_addr = NVSC_KEY2;
            3'h3: key_addr = NVSC_KEY3;
            3'h4: key_addr = NVSC_KEY4;
            default: key_addr = rec ? NVSC_KEY_RECALL :
                NVSC_KEY_STORE;
        endcase
    endfunction
    // ****************************************
    // sequencer
    // ****************************************
    nvsc_tmr_if tif ();
    nvsc_timer u_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .t(tif.tmr)
    );
    nvsc_state_e st_reg, st_next;
    logic [2:0] step_reg, step_next;
    logic [2:0] acc_reg, acc_next;
    logic rec_reg, rec_next;
    logic key_reg, key_next;
    logic pwr_reg, pwr_next;
    logic rdy_reg, rdy_next;
    logic rv_reg, rv_next;
    logic [NVSC_DW-1:0] rd_reg, rd_next;
    logic [NVSC_AW-1:0] a_reg, a_next;
    logic [NVSC_DW-1:0] d_reg, d_next;
    logic doe_n_reg, doe_n_next;
    logic ce_reg, ce_next;
    logic we_reg, we_next;
    logic oe_reg, oe_next;
    logic wr_reg, wr_next;
    logic [NVSC_CW-1:0] ld_cnt;
    logic ld;
    always_comb begin
        st_next = st_reg;
        step_next = step_reg;
        acc_next = acc_reg;
        rec_next = rec_reg;
        key_next = key_reg;
        pwr_next = pwr_reg;
        rdy_next = 1'b0;
        rv_next = 1'b0;
        rd_next = rd_reg;
        a_next = a_reg;
        d_next = d_reg;
        doe_n_next = doe_n_reg;
        ce_next = ce_reg;
        we_next = we_reg;
        oe_next = oe_reg;
        wr_next = wr_reg;
        ld = 1'b0;
        ld_cnt = NVSC_CW'(HRECALL_CYC);
        unique case (st_reg)
            NVSC_IDLE: begin
                if (pwr_reg) begin
                    // device is recalling after power up; keep we high
                    ld = 1'b1;
                    pwr_next = 1'b0;
                    st_next = NVSC_WAIT;
                end else if (cmd_valid_i && rdy_reg) begin
                    key_next = cmd_op_i[1];
                    rec_next = (cmd_op_i == NVSC_CMD_RECALL);
                    wr_next = (cmd_op_i == NVSC_CMD_WRITE);
                    step_next = '0;
                    a_next = cmd_op_i[1] ? {1'b0, key_addr(3'h0,
                        cmd_op_i[0])} : cmd_addr_i;
                    d_next = cmd_wdata_i;
                    st_next = NVSC_STRB;
                    acc_next = '0;
                end else begin
                    rdy_next = 1'b1;
                end
            end
            NVSC_STRB: begin
                // key reads strobe ce with we high, oe left high
                ce_next = 1'b0;
                we_next = ~wr_reg;
                oe_next = wr_reg | key_reg;
                doe_n_next = ~wr_reg;
                acc_next = acc_reg + 3'h1;
                if (acc_reg == 3'(NVSC_ACC_CYC)) begin
                    rd_next = din_s2_reg;
                    ce_next = 1'b1;
                    we_next = 1'b1;
                    oe_next = 1'b1;
                    doe_n_next = 1'b1;
                    acc_next = '0;
                    st_next = NVSC_GAP;
                end
            end
            NVSC_GAP: begin
                if (key_reg && step_reg != 3'(NVSC_KEY_LEN - 1)) begin
                    // back to back, nothing else may intervene
                    step_next = step_reg + 3'h1;
                    a_next = {1'b0, key_addr(step_reg + 3'h1, rec_reg)};
                    st_next = NVSC_STRB;
                end else if (key_reg) begin
                    // keyed store or recall issued, store even with no writes since
                    ld = 1'b1;
                    ld_cnt = rec_reg ? NVSC_CW'(RECALL_CYC) :
                        NVSC_CW'(STORE_CYC);
                    st_next = NVSC_WAIT;
                end else begin
                    st_next = NVSC_DONE;
                end
            end
            NVSC_WAIT: begin
                if (tif.expired) begin
                    st_next = NVSC_DONE;
                end
            end
            NVSC_DONE: begin
                rv_next = 1'b1;
                step_next = '0;
                key_next = 1'b0;
                st_next = NVSC_IDLE;
            end
            default: st_next = NVSC_IDLE;
        endcase
    end
    assign tif.load = ld;
    assign tif.count = ld_cnt;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= NVSC_IDLE;
            step_reg <= '0;
            acc_reg <= '0;
            rec_reg <= 1'b0;
            key_reg <= 1'b0;
            pwr_reg <= 1'b1;
            rdy_reg <= 1'b0;
            rv_reg <= 1'b0;
            rd_reg <= '0;
            a_reg <= '0;
            d_reg <= '0;
            doe_n_reg <= 1'b1;
            ce_reg <= 1'b1;
            we_reg <= 1'b1;
            oe_reg <= 1'b1;
            wr_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            step_reg <= step_next;
            acc_reg <= acc_next;
            rec_reg <= rec_next;
            key_reg <= key_next;
            pwr_reg <= pwr_next;
            rdy_reg <= rdy_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            a_reg <= a_next;
            d_reg <= d_next;
            doe_n_reg <= doe_n_next;
            ce_reg <= ce_next;
            we_reg <= we_next;
            oe_reg <= oe_next;
            wr_reg <= wr_next;
        end
    end
    assign cmd_ready_o = rdy_reg;
    assign rsp_valid_o = rv_reg;
    assign rsp_rdata_o = rd_reg;
    assign byte_address_o = a_reg;
    assign byte_lanes_o = d_reg;
    assign byte_lanes_oe_n_o = doe_n_reg;
    assign ce_n_o = ce_reg;
    assign we_n_o = we_reg;
    assign oe_n_o = oe_reg;
    // ****************************************
    // assertions
    // ****************************************
    sequence s_cmd_take;
        cmd_valid_i && rdy_reg;
    endsequence
    sequence s_cmd_busy;
        !rdy_reg && st_reg == NVSC_STRB;
    endsequence
    a_key_we_high: assert property (key_reg |-> we_reg)
        else $error("write strobe low during key");
    a_key_top_bit: assert property (key_reg |-> !a_reg[NVSC_AW-1])
        else $error("key address top bit set");
    a_key_first: assert property (
        (key_reg && step_reg == 3'h0 && !ce_reg) |->
        a_reg[NVSC_KEY_AW-1:0] == NVSC_KEY0)
        else $error("first key address wrong");
    a_key_sixth: assert property (
        (key_reg && step_reg == 3'(NVSC_KEY_LEN - 1) && !ce_reg) |->
        a_reg[NVSC_KEY_AW-1:0] ==
        (rec_reg ? NVSC_KEY_RECALL : NVSC_KEY_STORE))
        else $error("sixth key address wrong");
    a_wait_quiet: assert property (
        st_reg == NVSC_WAIT |-> ce_reg && we_reg)
        else $error("pins active while device busy");
    a_step_reset: assert property (
        st_reg == NVSC_DONE |=> step_reg == 3'h0 && !key_reg)
        else $error("key step not reset");
    a_read_strb: assert property (
        (!ce_reg && !wr_reg && !key_reg) |-> !oe_reg && we_reg)
        else $error("plain read strobes wrong");
    a_no_dq_key: assert property (key_reg |-> doe_n_reg)
        else $error("data driven during key");
    a_cmd_take: assert property (s_cmd_take |=> s_cmd_busy)
        else $error("command taken but not started alone");
endmodule

// ===== dv/nvsc_dev_model.sv
`timescale 1ns/1ps
module nvsc_dev_model
    import nvsc_pkg::*;
#(
    parameter int NV_NS = 300
)(
    // sampling clock and supply
    input wire logic clk_sys_i,
    input wire logic cap_low_i,
    // device pins
    input wire logic [NVSC_AW-1:0] byte_address_i,
    output logic [NVSC_DW-1:0] byte_lanes_o,
    input wire logic [NVSC_DW-1:0] byte_lanes_i,
    input wire logic byte_lanes_oe_n_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i
);
    logic [7:0] sram [32768];
    logic [7:0] shadow [32768];
    logic [13:0] keys [5];
    logic busy = 1'b1;
    logic in_cyc = 1'b0;
    logic wr_cyc = 1'b0;
    logic [7:0] junk = 8'h00;
    logic [14:0] a_q;
    logic [7:0] d_q;
    int step = 0;
    // ********
    // nonvolatile transfers
    // ********
    task automatic recall();
        busy = 1'b1;
        foreach (sram[i]) sram[i] = 8'h00;
        #(NV_NS);
        foreach (sram[i]) sram[i] = shadow[i];
        busy = 1'b0;
    endtask
    task automatic store();
        busy = 1'b1;
        foreach (shadow[i]) shadow[i] = 8'hFF;
        #(NV_NS);
        foreach (shadow[i]) shadow[i] = sram[i];
        busy = 1'b0;
    endtask
    initial begin
        keys = '{NVSC_KEY0, NVSC_KEY1, NVSC_KEY2, NVSC_KEY3, NVSC_KEY4};
        foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'hA5;
        recall();
    end
    // ********
    // pin cycles
    // ********
    assign byte_lanes_o = (!busy && !ce_n_i && !oe_n_i && we_n_i) ?
        sram[byte_address_i] : junk;
    task automatic end_cycle();
        logic [13:0] k;
        k = a_q[13:0];
        if (wr_cyc) begin
            if (!cap_low_i) sram[a_q] = d_q;
            step = 0;
        end else if (step < 5) begin
            step = (k == keys[step]) ? step + 1 :
                int'(k == NVSC_KEY0);
        end else begin
            step = 0;
            if (k == NVSC_KEY_STORE && !cap_low_i) store();
            else if (k == NVSC_KEY_RECALL) recall();
        end
        wr_cyc = 1'b0;
    endtask
    always @(posedge clk_sys_i) begin
        junk <= junk + 8'h3B;
        if (!ce_n_i && !busy) begin
            in_cyc = 1'b1;
            a_q = byte_address_i;
            if (!we_n_i) wr_cyc = 1'b1;
            if (!we_n_i && !byte_lanes_oe_n_i) d_q = byte_lanes_i;
        end else if (in_cyc) begin
            in_cyc = 1'b0;
            end_cycle();
        end
    end
endmodule

// ===== dv/nvsc_ctrl_test.sv
`timescale 1ns/1ps
module nvsc_ctrl_test;
    import nvsc_pkg::*;
    localparam int NV_CYC = 40;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cap_low = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [NVSC_AW-1:0] cmd_addr_i = '0;
    logic [NVSC_DW-1:0] cmd_wdata_i = '0;
    logic cmd_ready_o;
    logic rsp_valid_o;
    logic [NVSC_DW-1:0] rsp_rdata_o;
    logic [NVSC_AW-1:0] addr;
    logic [NVSC_DW-1:0] lanes_in;
    logic [NVSC_DW-1:0] lanes_out;
    logic lanes_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic in_key = 1'b0;
    logic boot = 1'b1;
    int miscompares = 0;
    int n_compared = 0;
    nvsc_ctrl #(.STORE_CYC(NV_CYC), .RECALL_CYC(NV_CYC),
        .HRECALL_CYC(NV_CYC)) u_nvsc_ctrl (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
        .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .byte_address_o(addr),
        .byte_lanes_i(lanes_in), .byte_lanes_o(lanes_out),
        .byte_lanes_oe_n_o(lanes_oe_n), .ce_n_o(ce_n), .we_n_o(we_n),
        .oe_n_o(oe_n));
    nvsc_dev_model #(.NV_NS(300)) u_nvsc_dev_model (.clk_sys_i(clk_sys_i),
        .cap_low_i(cap_low), .byte_address_i(addr),
        .byte_lanes_o(lanes_in), .byte_lanes_i(lanes_out),
        .byte_lanes_oe_n_i(lanes_oe_n), .ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n));
    // ********
    // shared tasks
    // ********
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic do_cmd(input logic [1:0] op, input logic [14:0] a,
            input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        cmd_op_i <= op;
        cmd_addr_i <= a;
        cmd_wdata_i <= wd;
        cmd_valid_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 6000);
        cmd_valid_i <= 1'b0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp_valid_o !== 1'b1 && n < 6000);
        rd = rsp_rdata_o;
        boot = 1'b0;
        if (n >= 6000) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] r;
        do_cmd(NVSC_CMD_WRITE, a, d, r);
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] r;
        do_cmd(NVSC_CMD_READ, a, 8'h00, r);
        check(r, e);
    endtask
    task automatic key(input logic [1:0] op);
        logic [7:0] r;
        in_key = 1'b1;
        do_cmd(op, 15'h0000, 8'h00, r);
        in_key = 1'b0;
    endtask
    task automatic rd_keys(input logic [14:0] first);
        logic [7:0] r;
        do_cmd(NVSC_CMD_READ, first, 8'h00, r);
        do_cmd(NVSC_CMD_READ, {1'b0, NVSC_KEY1}, 8'h00, r);
        do_cmd(NVSC_CMD_READ, {1'b0, NVSC_KEY2}, 8'h00, r);
        do_cmd(NVSC_CMD_READ, {1'b0, NVSC_KEY3}, 8'h00, r);
        do_cmd(NVSC_CMD_READ, {1'b0, NVSC_KEY4}, 8'h00, r);
    endtask
    always @(posedge clk_sys_i) begin
        if (in_key && ce_n === 1'b0) check(8'(we_n), 8'h01);
        if (boot && !rst_i && we_n !== 1'b1) check(8'(we_n), 8'h01);
    end
    // ********
    // scenarios
    // ********
    task automatic t_powerup();
        rd_chk(15'h0005, 8'hA0);
        rd_chk(15'h7FFF, 8'h5A);
    endtask
    task automatic t_rw();
        wr(15'h1234, 8'h3C);
        wr(15'h5234, 8'hC3);
        rd_chk(15'h1234, 8'h3C);
        rd_chk(15'h5234, 8'hC3);
    endtask
    task automatic t_lowcap();
        cap_low <= 1'b1;
        wr(15'h0100, 8'h99);
        rd_chk(15'h0100, 8'hA5);
        key(NVSC_CMD_STORE);
        cap_low <= 1'b0;
        wr(15'h0100, 8'h42);
        key(NVSC_CMD_RECALL);
        rd_chk(15'h0100, 8'hA5);
        rd_chk(15'h1234, 8'h91);
    endtask
    task automatic t_store_recall();
        wr(15'h0010, 8'h5A);
        wr(15'h4010, 8'h66);
        key(NVSC_CMD_STORE);
        rd_chk(15'h0010, 8'h5A);
        wr(15'h0010, 8'h00);
        key(NVSC_CMD_RECALL);
        rd_chk(15'h0010, 8'h5A);
        rd_chk(15'h4010, 8'h66);
        key(NVSC_CMD_RECALL);
        rd_chk(15'h0010, 8'h5A);
        key(NVSC_CMD_STORE);
        wr(15'h0010, 8'h11);
        key(NVSC_CMD_RECALL);
        rd_chk(15'h0010, 8'h5A);
    endtask
    task automatic t_abort();
        logic [7:0] r;
        wr(15'h0010, 8'h77);
        rd_keys({1'b0, NVSC_KEY0});
        wr(15'h0020, 8'h01);
        do_cmd(NVSC_CMD_READ, {1'b0, NVSC_KEY_RECALL}, 8'h00, r);
        rd_chk(15'h0010, 8'h77);
        rd_keys({1'b1, NVSC_KEY0});
        do_cmd(NVSC_CMD_READ, {1'b0, NVSC_KEY_RECALL}, 8'h00, r);
        repeat (NV_CYC) @(posedge clk_sys_i);
        rd_chk(15'h0010, 8'h5A);
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_powerup();
        t_rw();
        t_lowcap();
        t_store_recall();
        t_abort();
        summarize();
    end
endmodule
